// File: srw_host_model.sv
module srw_host_model (
  input wire logic clk,
  input wire logic kickEn,
  input wire logic [3:0] halfPer,
  output logic wdKick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] kickCnt_reg = 4'h0;
  initial wdKick = 1'h0;
  // kick pin stands still while supervision is off
  always @(posedge clk) begin
    if (!kickEn) kickCnt_reg <= 4'h0;
    else if (kickCnt_reg >= halfPer) begin
      kickCnt_reg <= 4'h0;
      wdKick <= ~wdKick;
    end else kickCnt_reg <= kickCnt_reg + 4'h1;
  end
endmodule // srw_host_model

// File: srw_supervisor.v
// Overview of operation
// - tolerance select low picks 5 percent thresholds, high picks 10 percent
// - coupled variant: kick held too long asserts reset and clears the timer
// - coupled variant: timer clears on reset or any kick edge
// - coupled variant: after reset, first kick may take the long startup delay
// - kick input left open disables the watchdog; host leaves it open to disable
// - separate variant: kick held too long asserts fault output; edges clear timer
// - separate variant: no startup window, normal timeout from the start
// - manual reset low asserts reset; held a timeout after release
// - timing pin tied to supply selects internal 140 ms timeout
// - capacitor fitted sets timeout as 2.06 Mohm times capacitance
// - reset asserts when any supply is low or manual reset is asserted
// - reset holds a timeout after all supplies good and manual reset off
// - separate variant: fault output low while any supply is below threshold
// - fault output releases at once when all supplies recover
// - separate variant: with supplies good, fault output asserts on watchdog expiry
// - fault output releases on a kick edge or manual reset low
// - separate variant: watchdog counts only after reset timeout ends
// - margin input low holds fault output deasserted
// - margin input low forces resetN and wdFaultOutN high
`include "srw_supervisor_defs.vh"

module srw_supervisor #(
  parameter [31:0] RST_CYC = `SRW_RST_TIMEOUT_MS * `SRW_CLK_KHZ,
  parameter [31:0] WD_CYC = `SRW_WD_TIMEOUT_MS * `SRW_CLK_KHZ,
  parameter [31:0] STARTUP_CYC = `SRW_STARTUP_MS * `SRW_CLK_KHZ
) (
  input wire clk,
  input wire rst_n,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // comparator flags, high = supply below threshold
  input wire [`SRW_NUM_IN-1:0] underVoltage,
  input wire manualResetN,
  input wire wdKickIn,
  // open-state detector, high = kick pin floating
  input wire wdKickOpen,
  input wire marginN,
  input wire thresholdToleranceSel,
  // high = timing pin tied to supply
  input wire resetTimingCapTied,
  // to comparators, high = 10 percent thresholds
  output reg thresholdWide,
  output reg resetN,
  output reg wdFaultOutN
);

  // first synchroniser stage
  reg [`SRW_NUM_IN-1:0] uvMeta_reg;
  reg mrMeta_reg;
  reg kickMeta_reg;
  reg openMeta_reg;
  reg marginMeta_reg;
  reg tolMeta_reg;
  reg capMeta_reg;

  // second synchroniser stage
  reg [`SRW_NUM_IN-1:0] uvSync_reg;
  reg mrSync_reg;
  reg kickSync_reg;
  reg openSync_reg;
  reg marginSync_reg;
  reg tolSync_reg;
  reg capSync_reg;

  // kick history for edge detection; resets to the idle low level
  // so that no false edge follows reset
  reg kickPrev_reg;

  // software registers
  reg separateMode_reg;
  reg [`SRW_CAP_W-1:0] capPf_reg;

  // reset timeout state
  reg resetActive_reg;
  reg [31:0] rstCnt_reg;

  // watchdog state
  reg [31:0] wdCnt_reg;
  reg startup_reg;
  reg wdFault_reg;
  reg wdResetReq_reg;

  wire anyUv;
  wire supplyFault;
  wire kickEdge;
  wire wdOff;
  wire marginOn;
  wire [31:0] capTarget;
  wire [31:0] rstTarget;
  wire [31:0] rstStep;
  wire [31:0] rstSum;
  wire rstDone;
  wire [31:0] wdLimit;
  wire wdExpire;
  wire busReq;
  wire [5:0] wordIdx;
  reg [31:0] readData;

  // next values of the reset hold and watchdog
  reg resetActive_next;
  reg [31:0] rstCnt_next;
  reg [31:0] wdCnt_next;
  reg startup_next;
  reg wdResetReq_next;
  reg wdFault_next;
  // next values of the software registers
  reg separateMode_next;
  reg [`SRW_CAP_W-1:0] capPf_next;
  // next values of the output flops
  reg thresholdWide_next;
  reg resetN_next;
  reg wdFaultOutN_next;

  // two flops on every pin input; only the second is read
  always @(posedge clk) begin
    if (!rst_n) begin
      uvMeta_reg <= {`SRW_NUM_IN{1'b0}};
      mrMeta_reg <= 1'b1;
      kickMeta_reg <= 1'b0;
      openMeta_reg <= 1'b0;
      marginMeta_reg <= 1'b1;
      tolMeta_reg <= 1'b0;
      capMeta_reg <= 1'b1;
      uvSync_reg <= {`SRW_NUM_IN{1'b0}};
      mrSync_reg <= 1'b1;
      kickSync_reg <= 1'b0;
      openSync_reg <= 1'b0;
      marginSync_reg <= 1'b1;
      tolSync_reg <= 1'b0;
      capSync_reg <= 1'b1;
      kickPrev_reg <= 1'b0;
    end else begin
      uvMeta_reg <= underVoltage;
      mrMeta_reg <= manualResetN;
      kickMeta_reg <= wdKickIn;
      openMeta_reg <= wdKickOpen;
      marginMeta_reg <= marginN;
      tolMeta_reg <= thresholdToleranceSel;
      capMeta_reg <= resetTimingCapTied;
      uvSync_reg <= uvMeta_reg;
      mrSync_reg <= mrMeta_reg;
      kickSync_reg <= kickMeta_reg;
      openSync_reg <= openMeta_reg;
      marginSync_reg <= marginMeta_reg;
      tolSync_reg <= tolMeta_reg;
      capSync_reg <= capMeta_reg;
      kickPrev_reg <= kickSync_reg;
    end
  end

  // combined fault and edge terms
  assign anyUv = |uvSync_reg;
  assign supplyFault = anyUv | ~mrSync_reg;
  assign kickEdge = kickSync_reg ^ kickPrev_reg;
  assign wdOff = openSync_reg;
  assign marginOn = ~marginSync_reg;

  // reset timeout source: internal count or capacitor scaled
  assign capTarget = capPf_reg * `SRW_CAP_MULT;
  assign rstTarget = capSync_reg ? RST_CYC : capTarget;
  assign rstStep = capSync_reg ? `SRW_ONE_STEP : `SRW_CAP_STEP;
  assign rstSum = rstCnt_reg + rstStep;
  // the capacitor path rounds the hold time up to whole cycles
  assign rstDone = (rstSum >= rstTarget);

  // reset hold next state: restarts on every fault, ends when the count is met
  always @* begin
    resetActive_next = resetActive_reg;
    rstCnt_next = rstCnt_reg;
    if (supplyFault || wdResetReq_reg) begin
      resetActive_next = 1'b1;
      rstCnt_next = 32'h0;
    end else if (resetActive_reg) begin
      if (rstDone) begin
        resetActive_next = 1'b0;
        rstCnt_next = 32'h0;
      end else begin
        rstCnt_next = rstSum;
      end
    end
  end

  // reset hold flops; the hold is armed out of reset
  always @(posedge clk) begin
    if (!rst_n) begin
      resetActive_reg <= 1'b1;
      rstCnt_reg <= 32'h0;
    end else begin
      resetActive_reg <= resetActive_next;
      rstCnt_reg <= rstCnt_next;
    end
  end

  // startup window only in the coupled variant
  assign wdLimit = (!separateMode_reg && startup_reg) ?
                   STARTUP_CYC : WD_CYC;
  assign wdExpire = !resetActive_reg && !wdOff &&
                    !kickEdge && (wdCnt_reg + 32'h1 >= wdLimit);

  // watchdog next state; held clear during reset so it starts after timeout
  always @* begin
    wdCnt_next = wdCnt_reg + 32'h1;
    startup_next = startup_reg;
    wdResetReq_next = 1'b0;
    if (resetActive_reg || wdOff) begin
      wdCnt_next = 32'h0;
      if (resetActive_reg) begin
        startup_next = 1'b1;
      end
    end else if (kickEdge) begin
      wdCnt_next = 32'h0;
      startup_next = 1'b0;
    end else if (wdExpire) begin
      wdCnt_next = 32'h0;
      // coupled variant turns expiry into a full reset
      wdResetReq_next = !separateMode_reg;
    end
  end

  // watchdog flops
  always @(posedge clk) begin
    if (!rst_n) begin
      wdCnt_reg <= 32'h0;
      startup_reg <= 1'b1;
      wdResetReq_reg <= 1'b0;
    end else begin
      wdCnt_reg <= wdCnt_next;
      startup_reg <= startup_next;
      wdResetReq_reg <= wdResetReq_next;
    end
  end

  // separate-variant fault latch; a kick edge wins over a new expiry
  always @* begin
    wdFault_next = wdFault_reg;
    if (!separateMode_reg) begin
      wdFault_next = 1'b0;
    end else if (!mrSync_reg || kickEdge) begin
      wdFault_next = 1'b0;
    end else if (wdExpire && !anyUv) begin
      wdFault_next = 1'b1;
    end
  end

  // fault latch flop
  always @(posedge clk) begin
    if (!rst_n) begin
      wdFault_reg <= 1'b0;
    end else begin
      wdFault_reg <= wdFault_next;
    end
  end

  // output next values; margin forces resetN and wdFaultOutN high
  always @* begin
    thresholdWide_next = tolSync_reg;
    resetN_next = ~resetActive_reg;
    // in the separate variant uv pulls fault low at once and releases with no delay
    wdFaultOutN_next = ~(separateMode_reg &&
                         (anyUv || wdFault_reg));
    if (marginOn) begin
      resetN_next = 1'b1;
      wdFaultOutN_next = 1'b1;
    end
  end

  // outputs straight from flops
  always @(posedge clk) begin
    if (!rst_n) begin
      resetN <= 1'b0;
      wdFaultOutN <= 1'b1;
      thresholdWide <= 1'b0;
    end else begin
      thresholdWide <= thresholdWide_next;
      resetN <= resetN_next;
      wdFaultOutN <= wdFaultOutN_next;
    end
  end

  // bus decode: word index from the byte address
  assign busReq = wb_cyc_i & wb_stb_i;
  assign wordIdx = wb_adr_i[7:2];

  // register writes, taken on the edge at which the master sees ack high
  always @* begin
    separateMode_next = separateMode_reg;
    capPf_next = capPf_reg;
    if (busReq && wb_we_i && wb_ack_o) begin
      case (wordIdx)
        `SRW_IDX_CTRL: begin
          if (wb_sel_i[0]) begin
            separateMode_next = wb_dat_i[`SRW_CTRL_SEPARATE];
          end
        end
        `SRW_IDX_CAP: begin
          if (wb_sel_i[0]) begin
            capPf_next[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            capPf_next[15:8] = wb_dat_i[15:8];
          end
        end
        default: begin
          capPf_next = capPf_reg; // unmapped writes are dropped
        end
      endcase
    end
  end

  // software register flops
  always @(posedge clk) begin
    if (!rst_n) begin
      separateMode_reg <= `SRW_CTRL_RESET;
      capPf_reg <= `SRW_CAP_RESET;
    end else begin
      separateMode_reg <= separateMode_next;
      capPf_reg <= capPf_next;
    end
  end

  // read mux; unmapped words read zero
  always @* begin
    readData = 32'h0;
    case (wordIdx)
      `SRW_IDX_CTRL: begin
        readData[`SRW_CTRL_SEPARATE] = separateMode_reg;
      end
      `SRW_IDX_CAP: begin
        readData[`SRW_CAP_W-1:0] = capPf_reg;
      end
      `SRW_IDX_STATUS: begin
        readData[`SRW_ST_RESET_N] = resetN;
        readData[`SRW_ST_FAULT_N] = wdFaultOutN;
        readData[`SRW_ST_STARTUP] = startup_reg;
        readData[`SRW_ST_WD_OFF] = wdOff;
        readData[`SRW_ST_MARGIN] = marginOn;
        readData[`SRW_ST_WIDE] = thresholdWide;
        readData[`SRW_ST_CAP_TIED] = capSync_reg;
        readData[`SRW_ST_WD_FAULT] = wdFault_reg;
        readData[`SRW_ST_UV_LSB +: `SRW_NUM_IN] = uvSync_reg;
      end
      default: begin
        readData = 32'h0;
      end
    endcase
  end

  // one-cycle acknowledge; drops the cycle after it was given
  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      if (busReq && !wb_ack_o) begin
        wb_dat_o <= readData;
      end
    end
  end

endmodule // srw_supervisor

// File: srw_supervisor_defs.vh
`ifndef SRW_SUPERVISOR_DEFS_VH
`define SRW_SUPERVISOR_DEFS_VH

// number of monitored supply inputs
`define SRW_NUM_IN 8

// clock rate in kHz (20 MHz)
`define SRW_CLK_KHZ 32'h4E20

// internal reset timeout, 140 ms minimum
`define SRW_RST_TIMEOUT_MS 32'h8C
// watchdog timeout, 1.6 s = 1600 ms
`define SRW_WD_TIMEOUT_MS 32'h640
// startup window after reset, 54 s = 54000 ms
`define SRW_STARTUP_MS 32'hD2F0

// capacitor timeout: 2.06e6 ohm x C x 20 MHz = 41.2 cycles per pF,
// done exactly as an accumulator stepping 10 per cycle toward C x 412
`define SRW_CAP_MULT 32'h19C
`define SRW_CAP_STEP 32'hA
`define SRW_ONE_STEP 32'h1

// register word indexes (byte address = index x 4)
`define SRW_IDX_CTRL 6'h00
`define SRW_IDX_CAP 6'h01
`define SRW_IDX_STATUS 6'h02

// control register fields
`define SRW_CTRL_SEPARATE 0
`define SRW_CTRL_RESET 1'h0

// capacitor register width and reset value
`define SRW_CAP_W 16
`define SRW_CAP_RESET 16'h0000

// status register fields
`define SRW_ST_RESET_N 0
`define SRW_ST_FAULT_N 1
`define SRW_ST_STARTUP 2
`define SRW_ST_WD_OFF 3
`define SRW_ST_MARGIN 4
`define SRW_ST_WIDE 5
`define SRW_ST_CAP_TIED 6
`define SRW_ST_WD_FAULT 7
`define SRW_ST_UV_LSB 8

`endif

// File: srw_supervisor_properties.sv
module srw_supervisor_properties #(
  parameter [31:0] RST_CYC = 32'h14
) (
  input wire clk,
  input wire rst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [7:0] underVoltage,
  input wire manualResetN,
  input wire marginN,
  input wire thresholdToleranceSel,
  input wire resetTimingCapTied,
  input wire thresholdWide,
  input wire resetN,
  input wire wdFaultOutN
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] goodCnt_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // cycles since supplies and manual reset were last all good
  always @(posedge clk) begin
    if (!rst_n || |underVoltage || !manualResetN) goodCnt_reg <= 32'h0;
    else goodCnt_reg <= goodCnt_reg + 32'h1;
  end
  margin_force_a: assert property ((rst_n && !marginN)[*4] |-> resetN && wdFaultOutN)
    else $error("margin did not force outputs high");
  uv_reset_a: assert property ((rst_n && marginN && |underVoltage)[*5] |-> !resetN)
    else $error("reset not asserted on low supply");
  mr_reset_a: assert property ((rst_n && marginN && !manualResetN)[*5] |-> !resetN)
    else $error("reset not asserted on manual reset");
  mr_fault_a: assert property ((rst_n && !manualResetN && underVoltage == 8'h00)[*5] |-> wdFaultOutN)
    else $error("fault output not released by manual reset");
  // margin or a timing-mode switch can raise reset early, so both must be steady
  hold_time_a: assert property ($rose(resetN) && marginN && $past(marginN, 4) && resetTimingCapTied
    && $past(resetTimingCapTied, 4) |-> goodCnt_reg >= RST_CYC)
    else $error("reset released before timeout");
  tol_copy_a: assert property (rst_n[*4] |-> thresholdWide == $past(thresholdToleranceSel, 3))
    else $error("tolerance output wrong");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  cover property ($rose(resetN));
  cover property ($fell(wdFaultOutN));
  cover property (wb_ack_o);
endmodule // srw_supervisor_properties

// File: srw_supervisor_tb_top.sv
module srw_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] RST_CYC = 32'h14;
  localparam [31:0] WD_CYC = 32'h10;
  localparam [31:0] STARTUP_CYC = 32'h28;
  logic clk = 1'h0, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, underVoltage = 8'h00;
  logic [3:0] wb_sel_i = 4'hF, kickHalf = 4'h3;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, ex;
  logic wb_ack_o, manualResetN = 1'h1, wdKickOpen = 1'h0, marginN = 1'h1, ok;
  logic thresholdToleranceSel = 1'h0, resetTimingCapTied = 1'h1, kickEn = 1'h0;
  logic thresholdWide, resetN, wdFaultOutN;
  wire wdKickIn;
  int fails = 0, compares = 0, n;
  srw_supervisor #(.RST_CYC(RST_CYC), .WD_CYC(WD_CYC), .STARTUP_CYC(STARTUP_CYC)) dut (
    .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .underVoltage, .manualResetN, .wdKickIn, .wdKickOpen, .marginN,
    .thresholdToleranceSel, .resetTimingCapTied, .thresholdWide, .resetN, .wdFaultOutN);
  srw_host_model host (.clk(clk), .kickEn(kickEn), .halfPer(kickHalf), .wdKick(wdKickIn));
  initial forever #25 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  // classic single cycle, held until ack is seen
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  // cycles until the chosen output reaches v, bounded
  task automatic waitFor(input logic fault, input logic v);
    n = 0;
    while ((fault ? wdFaultOutN : resetN) !== v && n < 500) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic inRange(input int lo, input int hi);
    check(n >= lo && n <= hi, 1'h1);
  endtask
  // 41.2 cycles per pF at 20 MHz, rounded up
  function automatic int expHold(input logic tied, input int cap);
    return tied ? RST_CYC : (cap * 412 + 9) / 10;
  endfunction
  task automatic holdRun(input logic tied, input logic [15:0] cap);
    resetTimingCapTied <= tied;
    wb(1'h1, 8'h04, {16'h0, cap});
    manualResetN <= 1'h0;
    tick(6);
    check(resetN, 1'h0);
    manualResetN <= 1'h1;
    waitFor(1'h0, 1'h1);
    inRange(expHold(tied, cap), expHold(tied, cap) + 8);
  endtask
  task automatic steady(input int k);
    ok = 1'h1;
    repeat (k) begin
      @(posedge clk);
      ok = ok & resetN;
    end
  endtask
  task automatic results;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    tick(20000);
    fails++;
    results;
  end
  initial begin
    n = $urandom(6);
    tick(2);
    rst_n <= 1'h1;
    foreach (ex[i]) if (i < 3) begin
      wb(1'h0, 8'(i * 4 + (i == 2) * 52), 32'h0);
      check(rd, 32'h0);
    end
    repeat (6) begin
      thresholdToleranceSel <= 1'($urandom_range(1));
      underVoltage <= 8'h01 << $urandom_range(7);
      tick(5);
      check(thresholdWide, thresholdToleranceSel);
      check(resetN, 1'h0);
      wb(1'h0, 8'h08, 32'h0);
      check(rd[15:8], underVoltage);
      underVoltage <= 8'h00;
      tick(2);
    end
    holdRun(1'h0, 16'($urandom_range(9, 1)));
    holdRun(1'h1, 16'h0);
    waitFor(1'h0, 1'h0);
    inRange(STARTUP_CYC - 2, STARTUP_CYC + 6);
    kickEn <= 1'h1;
    waitFor(1'h0, 1'h1);
    steady(100);
    check(ok, 1'h1);
    kickEn <= 1'h0;
    wdKickOpen <= 1'h1;
    steady(100);
    check(ok, 1'h1);
    wdKickOpen <= 1'h0;
    wb(1'h1, 8'h00, 32'h1);
    holdRun(1'h1, 16'h0);
    waitFor(1'h1, 1'h0);
    inRange(WD_CYC - 2, WD_CYC + 6);
    check(resetN, 1'h1);
    kickHalf <= 4'h0;
    kickEn <= 1'h1;
    tick(1);
    kickEn <= 1'h0;
    tick(5);
    check(wdFaultOutN, 1'h1);
    kickHalf <= 4'h3;
    kickEn <= 1'h1;
    underVoltage <= 8'h80;
    tick(5);
    check(wdFaultOutN, 1'h0);
    marginN <= 1'h0;
    tick(5);
    check({resetN, wdFaultOutN}, 2'h3);
    marginN <= 1'h1;
    underVoltage <= 8'h00;
    tick(5);
    check(wdFaultOutN, 1'h1);
    results;
  end
endmodule // srw_supervisor_tb_top
bind srw_supervisor srw_supervisor_properties #(.RST_CYC(RST_CYC)) chk (
  .clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .underVoltage, .manualResetN, .marginN,
  .thresholdToleranceSel, .resetTimingCapTied, .thresholdWide, .resetN, .wdFaultOutN);
